// ==== hdl/dpo_consts.svh ====
// constants for the diagnostic pin output configuration block
// Notes on behaviour
// (RULE1) bit 9 makes pin B push-pull when set and open-collector when clear, active low both ways.
// (RULE2) bit 8 makes pin A push-pull when set and open-collector when clear, active low both ways.
// (RULE3) bit 7 asserts pin B while axis 0 sits at microstep table entry zero.
// (RULE4) with the pin B source select clear, bit 6 enables stall indication on pin B.
// (RULE5) with the pin B source select set, bit 6 picks ramp direction (1) or position compare (0).
// (RULE6) software should set the stall velocity threshold before enabling stall on pin B.
// (RULE7) with the pin A source select clear, bit 5 enables stall indication on pin A.
// (RULE8) with the pin A source select set, bit 5 picks ramp step (1) or controller interrupts (0).
// (RULE9) bit 4 asserts pin A while the over-temperature prewarning is present.
// (RULE10) bit 3 asserts pin A on over-temperature or short to ground.
// (RULE11) pin A is driven low for as long as a reset condition lasts, whatever the settings.
// (RULE12) bit 2 reverses the axis 0 direction sense.
// (RULE13) bit 1 enables axis 0 step input filtering and resets to one.
// (RULE14) bit 0 enables axis 0 voltage PWM; off to on only at standstill with hold equal to run.
// (RULE15) several enabled sources on one pin combine as an OR of active-low indications.
`ifndef DPO_CONSTS_SVH
`define DPO_CONSTS_SVH
`define DPO_GLOBAL_CONFIG_ADDR 12'h000
`define DPO_STATUS_ADDR 12'h004
`define DPO_BIT_PWM_EN 0
`define DPO_BIT_STEP_FILT 1
`define DPO_BIT_DIR_INV 2
`define DPO_BIT_FAULT_EN 3
`define DPO_BIT_TEMP_WARN 4
`define DPO_BIT_A_STALL_STEP 5
`define DPO_BIT_B_STALL_DIR 6
`define DPO_BIT_B_INDEX 7
`define DPO_BIT_A_DRIVE 8
`define DPO_BIT_B_DRIVE 9
`define DPO_BIT_A_SRC 29
`define DPO_BIT_B_SRC 30
`define DPO_CFG_MASK 32'h600003FF
`define DPO_CFG_RESET 32'h00000002
`endif

// ==== hdl/dpo_diag_config.sv ====
// global configuration register, low bits, and diagnostic pin routing
`timescale 1ns/1ps
`include "dpo_consts.svh"
module dpo_diag_config
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stall_i,
    input wire logic index_pos_i,
    input wire logic pos_compare_i,
    input wire logic ramp_dir_i,
    input wire logic ramp_step_i,
    input wire logic ctrl_irq_i,
    input wire logic temp_warn_i,
    input wire logic overtemperature_i,
    input wire logic short_to_ground_i,
    input wire logic reset_cond_i,
    input wire logic standstill_i,
    input wire logic hold_eq_run_i,
    output logic fault_pin_a_o,
    output logic fault_pin_a_oe_o,
    output logic fault_pin_b_o,
    output logic fault_pin_b_oe_o,
    output logic axis0_direction_invert_o,
    output logic axis0_step_filter_enable_o,
    output logic axis0_voltage_pwm_enable_o,
    output dpo_pkg::dpo_drive_t pin_a_drive_o
);
    import dpo_pkg::*;

    logic [31:0] global_config_r;
    logic [31:0] global_config_nxt;
    logic [11:0] raw_in;
    wire logic [11:0] in_sync;
    logic stall_s;
    logic pos_compare_s;
    logic ramp_dir_s;
    logic ramp_step_s;
    logic index_pos_s;
    logic ctrl_irq_s;
    logic temp_warn_s;
    logic overtemp_s;
    logic short_gnd_s;
    logic reset_cond_s;
    logic standstill_s;
    logic hold_eq_run_s;
    logic pin_b_select_active;
    logic pin_b_index_active;
    logic pin_b_active;
    logic pin_a_select_active;
    logic pin_a_temp_active;
    logic pin_a_fault_active;
    logic pin_a_active;
    logic setup;
    logic access;
    logic addr_ok;
    logic cfg_write;
    logic pwm_switch_ok;
    logic pwm_refused_r;
    logic pwm_refused_nxt;

    // bit order matches the status word, hold_eq_run on top and hidden
    assign raw_in = {hold_eq_run_i, standstill_i, reset_cond_i, short_to_ground_i,
                     overtemperature_i, temp_warn_i, ctrl_irq_i, index_pos_i,
                     ramp_step_i, ramp_dir_i, pos_compare_i, stall_i};

    // two flops per input; only the second stage is read by any logic
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++)
        begin : g_sync
            logic stage1_r;
            logic stage2_r;
            always_ff @(posedge ref_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    stage1_r <= 1'b0;
                    stage2_r <= 1'b0;
                end
                else
                begin
                    stage1_r <= raw_in[gi];
                    stage2_r <= stage1_r;
                end
            end
            assign in_sync[gi] = stage2_r;
        end
    endgenerate

    // named views of the synchronised inputs
    assign stall_s = in_sync[0];
    assign pos_compare_s = in_sync[1];
    assign ramp_dir_s = in_sync[2];
    assign ramp_step_s = in_sync[3];
    assign index_pos_s = in_sync[4];
    assign ctrl_irq_s = in_sync[5];
    assign temp_warn_s = in_sync[6];
    assign overtemp_s = in_sync[7];
    assign short_gnd_s = in_sync[8];
    assign reset_cond_s = in_sync[9];
    assign standstill_s = in_sync[10];
    assign hold_eq_run_s = in_sync[11];

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign addr_ok = (paddr == `DPO_GLOBAL_CONFIG_ADDR) | (paddr == `DPO_STATUS_ADDR);
    assign cfg_write = access & pwrite & (paddr == `DPO_GLOBAL_CONFIG_ADDR);
    // both qualifiers are two cycles old; software must hold them across the write
    assign pwm_switch_ok = standstill_s & hold_eq_run_s;

    always_comb
    begin
        global_config_nxt = global_config_r;
        pwm_refused_nxt = pwm_refused_r;
        if (cfg_write)
        begin
            global_config_nxt = pwdata & `DPO_CFG_MASK;
            pwm_refused_nxt = 1'b0;
            // off to on only at standstill with hold equal to run; else kept off
            if (!global_config_r[`DPO_BIT_PWM_EN] && pwdata[`DPO_BIT_PWM_EN]
                && !pwm_switch_ok) // RULE14
            begin
                global_config_nxt[`DPO_BIT_PWM_EN] = 1'b0;
                pwm_refused_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            global_config_r <= `DPO_CFG_RESET; // RULE13
        end
        else
        begin
            global_config_r <= global_config_nxt;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pwm_refused_r <= 1'b0;
        end
        else
        begin
            pwm_refused_r <= pwm_refused_nxt;
        end
    end

    // zero-wait slave: ready in the access cycle after every setup
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= setup;
        end
    end

    // unmapped addresses answer with an error; the write is dropped
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pslverr <= 1'b0;
        end
        else
        begin
            pslverr <= setup & ~addr_ok;
        end
    end

    // read data captured at setup and held until the next read
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            prdata <= 32'h00000000;
        end
        else if (setup && !pwrite)
        begin
            if (paddr == `DPO_GLOBAL_CONFIG_ADDR)
                prdata <= global_config_r;
            else if (paddr == `DPO_STATUS_ADDR)
                prdata <= {20'h00000, pwm_refused_r, in_sync[10:0]};
            else
                prdata <= 32'h00000000;
        end
    end

    // pin B: source select picks stall, or compare versus direction
    always_comb
    begin
        pin_b_select_active = 1'b0;
        if (!global_config_r[`DPO_BIT_B_SRC])
            pin_b_select_active = global_config_r[`DPO_BIT_B_STALL_DIR] & stall_s; // RULE4
        else if (global_config_r[`DPO_BIT_B_STALL_DIR])
            pin_b_select_active = ramp_dir_s; // RULE5
        else
            pin_b_select_active = pos_compare_s; // RULE5
    end

    assign pin_b_index_active = global_config_r[`DPO_BIT_B_INDEX] & index_pos_s; // RULE3
    assign pin_b_active = pin_b_select_active | pin_b_index_active; // RULE15

    // pin A: source select picks stall, or ramp step versus controller interrupts
    always_comb
    begin
        pin_a_select_active = 1'b0;
        if (!global_config_r[`DPO_BIT_A_SRC])
            pin_a_select_active = global_config_r[`DPO_BIT_A_STALL_STEP] & stall_s; // RULE7
        else if (global_config_r[`DPO_BIT_A_STALL_STEP])
            pin_a_select_active = ramp_step_s; // RULE8
        else
            pin_a_select_active = ctrl_irq_s; // RULE8
    end

    assign pin_a_temp_active = global_config_r[`DPO_BIT_TEMP_WARN] & temp_warn_s; // RULE9
    assign pin_a_fault_active = global_config_r[`DPO_BIT_FAULT_EN]
                                & (overtemp_s | short_gnd_s); // RULE10
    // reset status overrides every pin A setting
    assign pin_a_active = pin_a_select_active | pin_a_temp_active | pin_a_fault_active
                          | reset_cond_s; // RULE11 RULE15

    dpo_pin_driver u_pin_a
    (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .active_i(pin_a_active),
        .push_pull_i(global_config_r[`DPO_BIT_A_DRIVE]), // RULE2
        .pin_o(fault_pin_a_o),
        .pin_oe_o(fault_pin_a_oe_o)
    );

    dpo_pin_driver u_pin_b
    (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .active_i(pin_b_active),
        .push_pull_i(global_config_r[`DPO_BIT_B_DRIVE]), // RULE1
        .pin_o(fault_pin_b_o),
        .pin_oe_o(fault_pin_b_oe_o)
    );

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            axis0_direction_invert_o <= 1'b0;
        end
        else
        begin
            axis0_direction_invert_o <= global_config_r[`DPO_BIT_DIR_INV]; // RULE12
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            axis0_step_filter_enable_o <= 1'b1;
        end
        else
        begin
            axis0_step_filter_enable_o <= global_config_r[`DPO_BIT_STEP_FILT]; // RULE13
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            axis0_voltage_pwm_enable_o <= 1'b0;
        end
        else
        begin
            axis0_voltage_pwm_enable_o <= global_config_r[`DPO_BIT_PWM_EN]; // RULE14
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pin_a_drive_o <= DPO_OPEN_COLLECTOR;
        end
        else
        begin
            pin_a_drive_o <= global_config_r[`DPO_BIT_A_DRIVE] ? DPO_PUSH_PULL
                                                                : DPO_OPEN_COLLECTOR;
        end
    end
endmodule

// ==== hdl/dpo_pin_driver.sv ====
// registered active-low pin driver with open-collector or push-pull drive
`timescale 1ns/1ps
module dpo_pin_driver
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic active_i,
    input wire logic push_pull_i,
    output logic pin_o,
    output logic pin_oe_o
);
    // pin low when active; open collector releases instead of driving high
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pin_o <= 1'b0;
            pin_oe_o <= 1'b1;
        end
        else
        begin
            pin_o <= ~active_i;
            pin_oe_o <= active_i | push_pull_i;
        end
    end
endmodule

// ==== hdl/dpo_pkg.sv ====
// types for the diagnostic pin output configuration block
package dpo_pkg;
    typedef enum logic [1:0] {
        DPO_OPEN_COLLECTOR = 2'h1,
        DPO_PUSH_PULL = 2'h2
    } dpo_drive_t;
endpackage

// ==== testbench/dpo_diag_config_monitor.sv ====
// assertion checker for the diagnostic pin configuration block
`timescale 1ns/1ps
`include "dpo_consts.svh"
module dpo_diag_config_monitor
import dpo_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic reset_cond_i,
    input wire logic standstill_i,
    input wire logic hold_eq_run_i,
    input wire logic fault_pin_a_o,
    input wire logic fault_pin_a_oe_o,
    input wire logic axis0_direction_invert_o,
    input wire logic axis0_voltage_pwm_enable_o,
    input wire dpo_drive_t pin_a_drive_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wr0;
        psel && penable && pready && pwrite && paddr == 12'h000;
    endsequence
    sequence s_rd0;
        psel && !penable && !pwrite && paddr == 12'h000;
    endsequence
    AST_RDY: assert property (s_setup |=> pready) else $error("no ready");
    AST_PHS: assert property (pready |-> psel && penable) else $error("stray ready");
    AST_ERR: assert property (s_setup and paddr > 12'h004 |=> pslverr) else $error("no error");
    AST_MASK: assert property (s_rd0 |=> (prdata & ~`DPO_CFG_MASK) == 32'h0)
        else $error("unmasked bits");
    AST_DIR: assert property (s_wr0 |-> ##2 axis0_direction_invert_o == $past(pwdata[2], 2))
        else $error("direction bit");
    AST_PWM: assert property ($rose(axis0_voltage_pwm_enable_o)
        |-> $past(standstill_i, 4) && $past(hold_eq_run_i, 4)) else $error("pwm while moving");
    AST_OC: assert property ((pin_a_drive_o == DPO_OPEN_COLLECTOR)[*3]
        |-> !(fault_pin_a_oe_o && fault_pin_a_o)) else $error("open collector high");
    AST_RST: assert property (reset_cond_i[*6] |-> fault_pin_a_oe_o && !fault_pin_a_o)
        else $error("pin a not low");
endmodule
bind dpo_diag_config dpo_diag_config_monitor mon_inst (.ref_clk_i, .nrst_i, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_cond_i, .standstill_i,
    .hold_eq_run_i,
    .fault_pin_a_o, .fault_pin_a_oe_o, .axis0_direction_invert_o, .axis0_voltage_pwm_enable_o,
    .pin_a_drive_o);

// ==== testbench/dpo_diag_config_tb.sv ====
// self-checking bench for the diagnostic pin configuration block
`timescale 1ns/1ps
module dpo_diag_config_tb;
    import dpo_pkg::*;
    logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, err;
    logic [11:0] paddr = 12'h000, src = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, a_o, a_oe, b_o, b_oe, lva, lvb, dir, filt, pwm;
    dpo_drive_t drv;
    int mismatches = 0, n_compared = 0;
    localparam logic [31:0] CFG [16] = '{32'h2, 32'h40, 32'h80, 32'h40000000, 32'h40000000,
        32'h40000040, 32'h40000040, 32'h20, 32'h20000000, 32'h20000020, 32'h20000020,
        32'h10, 32'h18, 32'h308, 32'h306, 32'h0};
    localparam logic [11:0] SRC [16] = '{12'h1FF, 12'h1, 12'h2, 12'h4, 12'h1, 12'h8, 12'h4,
        12'h1, 12'h20, 12'h10, 12'h20, 12'h40, 12'h100, 12'h80, 12'h0, 12'h200};
    localparam logic [1:0] EXP [16] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2,
        2'h2, 2'h2, 2'h0, 2'h2, 2'h2, 2'h2, 2'h0, 2'h2};
    dpo_diag_config dpo_diag_config_inst (.ref_clk_i(clk), .nrst_i(nrst), .psel, .penable(pen),
        .pwrite(pwr), .paddr, .pwdata, .prdata, .pready, .pslverr, .stall_i(src[0]),
        .index_pos_i(src[1]), .pos_compare_i(src[2]), .ramp_dir_i(src[3]),
        .ramp_step_i(src[4]), .ctrl_irq_i(src[5]), .temp_warn_i(src[6]),
        .overtemperature_i(src[7]), .short_to_ground_i(src[8]), .reset_cond_i(src[9]),
        .standstill_i(src[10]), .hold_eq_run_i(src[11]), .fault_pin_a_o(a_o),
        .fault_pin_a_oe_o(a_oe), .fault_pin_b_o(b_o), .fault_pin_b_oe_o(b_oe),
        .axis0_direction_invert_o(dir), .axis0_step_filter_enable_o(filt),
        .axis0_voltage_pwm_enable_o(pwm), .pin_a_drive_o(drv));
    dpo_host_model dpo_host_model_inst (.pin_a_i(a_o), .pin_a_oe_i(a_oe), .pin_b_i(b_o),
        .pin_b_oe_i(b_oe), .level_a_o(lva), .level_b_o(lvb));
    initial
    begin
        forever #4 clk = ~clk;
    end
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        if (i == 20)
        begin
            mismatches++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic t_regs();
        apb(1'b0, 12'h000, 32'h0);
        chk("reset value", rd, 32'h00000002);
        chk("filter reset", 32'(filt), 32'h1);
        apb(1'b1, 12'h008, 32'hFFFFFFFF);
        chk("unmapped error", 32'(err), 32'h1);
        apb(1'b1, 12'h000, 32'hFFFFFFFE);
        apb(1'b0, 12'h000, 32'h0);
        chk("config rw", rd, 32'h600003FE);
        $display("regs done");
    endtask
    task automatic t_pins();
        logic a, b;
        for (int k = 0; k < 16; k++)
        begin
            apb(1'b1, 12'h000, CFG[k]);
            src <= SRC[k]; // stall input arrives already qualified
            repeat (8) @(posedge clk);
            a = EXP[k][1];
            b = EXP[k][0];
            chk("pin a", 32'({drv, dir, filt, a_oe, lva}), 32'({CFG[k][8], ~CFG[k][8],
                CFG[k][2:1], a | CFG[k][8], ~a}));
            chk("pin b", 32'({b_oe, lvb}), 32'({b | CFG[k][9], ~b}));
        end
        $display("pins done");
    endtask
    task automatic t_pwm();
        src <= 12'h400;
        repeat (6) @(posedge clk);
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b0, 12'h004, 32'h0);
        chk("refused flag", 32'(rd[11]), 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk("pwm blocked", rd, 32'h2);
        src <= 12'hC00;
        repeat (6) @(posedge clk);
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b0, 12'h000, 32'h0);
        chk("pwm on", 32'({rd[1:0], pwm}), 32'h7);
        $display("pwm done");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        chk("pins in reset", 32'({lva, lvb}), 32'h0);
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_pins();
        t_pwm();
        close_out();
    end
endmodule

// ==== testbench/dpo_host_model.sv ====
// host side of the diagnostic pins, with pull-ups
`timescale 1ns/1ps
module dpo_host_model
(
    input wire logic pin_a_i,
    input wire logic pin_a_oe_i,
    input wire logic pin_b_i,
    input wire logic pin_b_oe_i,
    output logic level_a_o,
    output logic level_b_o
);
    // a released pin floats up, so open collector reads high
    assign level_a_o = pin_a_oe_i ? pin_a_i : 1'b1;
    assign level_b_o = pin_b_oe_i ? pin_b_i : 1'b1;
endmodule
